// file: hw/period_match_timer8.sv
// Eight-bit period match timer with AXI4-Lite register access.
// Assumes a single clock; clk_en low freezes all state, bus included.
//
// Summary of operation
// [R01] Count increments per prescaled instruction clock
// [R02] Prescaler divides by 1, 4 or 16
// [R03] Count equal to period gives match pulse
// [R04] After match count reloads zero
// [R05] Postscaler divides matches by select plus one
// [R06] Postscaler completion sets sticky match flag
// [R07] Flag interrupts only while enable bit set
// [R08] Reset clears count, sets period all ones
// [R09] Count/control writes and resets clear scalers
// [R10] Control write keeps the count value
// [R11] On bit runs or stops the timer
// [R12] Count and period readable and writable anytime
// [R13] Timer off holds state, no matches
`timescale 1ns/1ns
`default_nettype none

module period_match_timer8
  import timer8_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic        irq,
  output var  logic        match_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  logic        awready_q, awready_d;
  logic        wready_q, wready_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        aw_full_q, aw_full_d;
  logic        w_full_q, w_full_d;
  logic [7:0]  waddr_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;

  logic        aw_hs, w_hs, ar_hs;
  logic        aw_have, w_have, do_wr;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_lane;
  reg_sel_t    wr_sel, rd_sel;
  logic        wr_count, wr_period, wr_ctrl, wr_mask;
  logic        rd_clr;
  logic [7:0]  rd_byte;

  // Timer state
  logic [7:0]  count_q, count_d;
  logic [7:0]  period_q, period_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  mask_q, mask_d;
  logic        flag_q, flag_d;
  logic        irq_q, irq_d;
  logic        match_q, match_d;
  logic [1:0]  phase_q, phase_d;
  logic        timer_on;
  logic        at_period;

  scaler_if sc ();

  scaler_counters u_scaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .sc      (sc.scaler)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order
  assign aw_hs   = clk_en & awvalid & awready_q;
  assign w_hs    = clk_en & wvalid & wready_q;
  assign aw_have = aw_full_q | aw_hs;
  assign w_have  = w_full_q | w_hs;
  assign do_wr   = aw_have & w_have;
  assign wr_addr = aw_full_q ? waddr_q : awaddr;
  assign wr_byte = w_full_q ? wdata_q : wdata[7:0];
  assign wr_lane = w_full_q ? wlane_q : wstrb[0];
  assign wr_sel  = decode_addr(wr_addr);

  // Registers sit in byte lane 0; other lanes are ignored
  assign wr_count  = do_wr & wr_lane & (wr_sel == SEL_COUNT);
  assign wr_period = do_wr & wr_lane & (wr_sel == SEL_PERIOD);
  assign wr_ctrl   = do_wr & wr_lane & (wr_sel == SEL_CONTROL);
  assign wr_mask   = do_wr & wr_lane & (wr_sel == SEL_MASK);

  assign aw_full_d = aw_have & ~do_wr;
  assign w_full_d  = w_have & ~do_wr;
  assign bvalid_d  = do_wr | (bvalid_q & ~bready);
  assign awready_d = ~aw_full_d & ~bvalid_d;
  assign wready_d  = ~w_full_d & ~bvalid_d;
  assign bresp_d   = !do_wr ? bresp_q :
                     (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  // Read channel: one read at a time, data registered
  assign ar_hs     = clk_en & arvalid & arready_q;
  assign rd_sel    = decode_addr(araddr);
  assign rd_clr    = ar_hs & (rd_sel == SEL_STATUS);
  assign rd_byte   = (rd_sel == SEL_COUNT)   ? count_q :          // [R12]
                     (rd_sel == SEL_PERIOD)  ? period_q :
                     (rd_sel == SEL_CONTROL) ? ctrl_q :
                     (rd_sel == SEL_STATUS)  ? {7'h00, flag_q} :
                     (rd_sel == SEL_MASK)    ? mask_q : 8'h00;
  assign rvalid_d  = ar_hs | (rvalid_q & ~rready);
  assign arready_d = ~rvalid_d;
  assign rdata_d   = ar_hs ? {24'h0000_00, rd_byte} : rdata_q;
  assign rresp_d   = !ar_hs ? rresp_q :
                     (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else if (clk_en) begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      if (aw_hs) begin
        waddr_q <= awaddr;
      end
      if (w_hs) begin
        wdata_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer core
  assign timer_on  = ctrl_q[ON_BIT];                              // [R11]
  assign at_period = (count_q == period_q);                       // [R03]
  assign phase_d   = timer_on ? phase_q + 2'h1 : phase_q;         // [R13]

  assign sc.instr_tick    = clk_en & timer_on &
                            (phase_q == PHASE_LAST);              // [R01]
  assign sc.clear         = wr_count | wr_ctrl;                   // [R09]
  assign sc.prescale_sel  = ctrl_q[PRE_MSB:PRE_LSB];
  assign sc.postscale_sel = ctrl_q[POST_MSB:POST_LSB];
  assign sc.match         = match_q;

  // Period lowered below the count: count runs on through FFh to 00h
  assign count_d  = wr_count      ? wr_byte :                     // [R12]
                    sc.count_tick ? (at_period ? COUNT_RESET :    // [R04]
                                     count_q + 8'h01) :           // [R01]
                    count_q;                                      // [R10]
  assign match_d  = sc.count_tick & at_period;                    // [R03]
  assign period_d = wr_period ? wr_byte : period_q;               // [R12]
  assign ctrl_d   = wr_ctrl ? (wr_byte & CONTROL_WMASK) : ctrl_q;
  assign mask_d   = wr_mask ? {7'h00, wr_byte[FLAG_BIT]} : mask_q;
  // Set wins over the read that clears
  assign flag_d   = sc.post_done | (flag_q & ~rd_clr);            // [R06]
  assign irq_d    = flag_d & mask_d[FLAG_BIT];                    // [R07]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q  <= COUNT_RESET;                                    // [R08]
      period_q <= PERIOD_RESET;                                   // [R08]
      ctrl_q   <= CONTROL_RESET;
      mask_q   <= MASK_RESET;
      flag_q   <= 1'b0;
      irq_q    <= 1'b0;
      match_q  <= 1'b0;
      phase_q  <= 2'h0;
    end else if (clk_en) begin
      count_q  <= count_d;
      period_q <= period_d;
      ctrl_q   <= ctrl_d;
      mask_q   <= mask_d;
      flag_q   <= flag_d;
      irq_q    <= irq_d;
      match_q  <= match_d;
      phase_q  <= phase_d;
    end
  end

  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign irq       = irq_q;
  assign match_out = match_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_COUNT_INC: assert property (@(posedge aclk) disable iff (!aresetn)
    (sc.count_tick && !at_period && !wr_count)
    |=> (count_q == $past(count_q) + 8'h01))                      // [R01]
    else $error("count did not advance by one");

  AST_INSTR_SPACING: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (sc.instr_tick && clk_en) |=> !sc.instr_tick [*3])            // [R01]
    else $error("instruction ticks closer than four clocks");

  AST_MATCH_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    (sc.count_tick && at_period) |=> (match_out && count_q == 8'h00)) // [R03]
    else $error("match pulse or zero reload missing");

  AST_MATCH_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(match_out) |-> $past(count_q == period_q))              // [R03]
    else $error("match pulse without equality");

  AST_RESET_VALUES: assert property (@(posedge aclk)
    !aresetn |=> (count_q == 8'h00 && period_q == 8'hFF && !irq)) // [R08]
    else $error("wrong reset values");

  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    sc.post_done |=> flag_q)                                      // [R06]
    else $error("postscaler completion did not set flag");

  AST_IRQ_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && flag_d && !mask_d[FLAG_BIT]) |=> !irq)             // [R07]
    else $error("interrupt raised while disabled");

  AST_CTRL_KEEPS_COUNT: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (wr_ctrl && !wr_count) |=> $stable(count_q))                  // [R10]
    else $error("control write changed the count");

  AST_OFF_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    (!timer_on && !wr_count) |=> ($stable(count_q) && !sc.post_done)) // [R13]
    else $error("stopped timer changed state");

  AST_COUNT_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_count |=> (count_q == $past(wr_byte)))                     // [R12]
    else $error("count write lost");

  // Read-to-clear must not swallow a flag set in the same cycle
  AST_FLAG_SET_WINS: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (sc.post_done && rd_clr) |=> flag_q)                          // [R06]
    else $error("flag set lost against status read");

  AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (flag_q && mask_q[FLAG_BIT]))                          // [R07]
    else $error("interrupt level differs from flag and mask");

  AST_BVALID_HOLD: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (bvalid && !(bready && clk_en)) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before handshake");

  AST_RVALID_HOLD: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (rvalid && !(rready && clk_en)) |=> (rvalid && $stable(rdata)))
    else $error("read data dropped before handshake");

  AST_AR_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> !arready)
    else $error("read address accepted while data pending");

endmodule : period_match_timer8

`default_nettype wire

// file: hw/scaler_counters.sv
// Four-bit prescale and postscale counters of the period match timer.
// Assumes instr_tick and clear already carry the clock enable.
`timescale 1ns/1ns
`default_nettype none

module scaler_counters
  import timer8_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  scaler_if.scaler sc
);

  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [3:0] post_q;
  logic [3:0] post_d;
  logic       pre_end;
  logic       post_end;

  ////////////////////////////////////////////////////////////////////////////
  assign pre_end  = (pre_q == prescale_last(sc.prescale_sel));  // [R02]
  assign post_end = (post_q == sc.postscale_sel);                // [R05]
  // A clear takes precedence over a tick in the same cycle
  assign sc.count_tick = sc.instr_tick & pre_end & ~sc.clear;    // [R02]
  assign sc.post_done  = clk_en & sc.match & post_end & ~sc.clear; // [R05]

  assign pre_d  = sc.clear      ? 4'h0 :                         // [R09]
                  sc.instr_tick ? (pre_end ? 4'h0 : pre_q + 4'h1) :
                  pre_q;
  assign post_d = sc.clear                ? 4'h0 :               // [R09]
                  (clk_en & sc.match)     ? (post_end ? 4'h0 : post_q + 4'h1) :
                  post_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q  <= 4'h0;                                            // [R09]
      post_q <= 4'h0;
    end else if (clk_en) begin
      pre_q  <= pre_d;
      post_q <= post_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_SCALER_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    sc.clear |=> (pre_q == 4'h0) && (post_q == 4'h0))            // [R09]
    else $error("scaler counters not cleared");

  AST_PRESCALE_DIV16: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (sc.count_tick && sc.prescale_sel[1]) |-> (pre_q == 4'hF))   // [R02]
    else $error("divide by 16 ticked early");

  AST_POSTSCALE_COUNT: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sc.post_done |=> (post_q == 4'h0))                           // [R05]
    else $error("postscaler did not restart after completion");

endmodule : scaler_counters

`default_nettype wire

// file: inc/scaler_if.sv
// Signals between the timer core and its prescale/postscale counters.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface scaler_if;
  logic       instr_tick;
  logic       clear;
  logic [1:0] prescale_sel;
  logic [3:0] postscale_sel;
  logic       match;
  logic       count_tick;
  logic       post_done;

  modport timer (
    output instr_tick,
    output clear,
    output prescale_sel,
    output postscale_sel,
    output match,
    input  count_tick,
    input  post_done
  );

  modport scaler (
    input  instr_tick,
    input  clear,
    input  prescale_sel,
    input  postscale_sel,
    input  match,
    output count_tick,
    output post_done
  );
endinterface : scaler_if

`default_nettype wire

// file: inc/timer8_pkg.sv
// Constants, register map and helper functions of the period match timer.
// Assumes a 32-bit AXI4-Lite slave with byte addresses on eight bits.
`default_nettype none

package timer8_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_COUNT   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_MASK    = 8'h10;

  typedef enum logic [2:0] {
    SEL_NONE    = 3'b000,
    SEL_COUNT   = 3'b001,
    SEL_PERIOD  = 3'b010,
    SEL_CONTROL = 3'b011,
    SEL_STATUS  = 3'b100,
    SEL_MASK    = 3'b101
  } reg_sel_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field layout
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h7F;
  localparam int         PRE_LSB       = 0;
  localparam int         PRE_MSB       = 1;
  localparam int         ON_BIT        = 2;
  localparam int         POST_LSB      = 3;
  localparam int         POST_MSB      = 6;
  localparam int         FLAG_BIT      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: instruction clock is the bus clock divided by four
  localparam int         INSTR_DIV   = 4;
  localparam logic [1:0] PHASE_LAST  = 2'(INSTR_DIV - 1);
  localparam logic [3:0] PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic reg_sel_t decode_addr(input logic [7:0] a);
    case (a)
      ADDR_COUNT:   decode_addr = SEL_COUNT;
      ADDR_PERIOD:  decode_addr = SEL_PERIOD;
      ADDR_CONTROL: decode_addr = SEL_CONTROL;
      ADDR_STATUS:  decode_addr = SEL_STATUS;
      ADDR_MASK:    decode_addr = SEL_MASK;
      default:      decode_addr = SEL_NONE;
    endcase
  endfunction : decode_addr

  function automatic logic [3:0] prescale_last(input logic [1:0] s);
    if (s[1]) begin
      prescale_last = PRE_LAST_16;
    end else if (s[0]) begin
      prescale_last = PRE_LAST_4;
    end else begin
      prescale_last = PRE_LAST_1;
    end
  endfunction : prescale_last

endpackage : timer8_pkg

`default_nettype wire

// file: verification/period_match_timer8_bench.sv
// Self-checking bench of the period match timer, driven over AXI4-Lite.
// Assumes the design's own assertions; clk_en held high throughout.
`timescale 1ns/1ns
`default_nettype none

module period_match_timer8_bench;
  import timer8_pkg::*;

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en  = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, match_out;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          error_cnt  = 0;
  int          n_compared = 0;
  int          match_cnt  = 0;

  always #25 aclk = ~aclk;
  always @(posedge aclk) if (match_out === 1'b1) match_cnt <= match_cnt + 1;

  period_match_timer8 i_period_match_timer8 (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .match_out(match_out)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_up(input string what);
    error_cnt++;
    $display("MISMATCH %s expected answer seen timeout", what);
    tally_and_finish();
  endtask : give_up

  // Called right after a rising edge; returns at the B handshake edge
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                           output logic [1:0] resp);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (n >= 50) give_up("write response");
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (n >= 50) give_up("read response");
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // Edges until match_out is sampled high
  task automatic wait_match(output int c);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (match_out !== 1'b1 && c < 3000);
    if (c >= 3000) give_up("match pulse");
  endtask : wait_match

  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(ADDR_COUNT, d, r);
    check("count reset", d, 32'h0000_0000);
    axi_read(ADDR_PERIOD, d, r);
    check("period reset", d, 32'h0000_00FF);
    axi_read(ADDR_CONTROL, d, r);
    check("control reset", d, 32'h0000_0000);
    axi_read(8'h14, d, r);
    check("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
    axi_write(8'h14, 8'h55, r);
    check("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
    check("irq idle", 32'(irq), 32'h0000_0000);
    $display("done: reset");
  endtask : test_reset

  task automatic test_rw;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(ADDR_COUNT, 8'h5A, r);
    check("write resp", 32'(r), 32'(RESP_OKAY));
    axi_read(ADDR_COUNT, d, r);
    check("count rw", d, 32'h0000_005A);
    axi_write(ADDR_PERIOD, 8'h33, r);
    axi_read(ADDR_PERIOD, d, r);
    check("period rw", d, 32'h0000_0033);
    // Top bit of control is unimplemented
    axi_write(ADDR_CONTROL, 8'hFB, r);
    axi_read(ADDR_CONTROL, d, r);
    check("control rw", d, 32'h0000_007B);
    $display("done: register access");
  endtask : test_rw

  task automatic test_period;
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    axi_write(ADDR_MASK, 8'h01, r);
    axi_write(ADDR_PERIOD, 8'h02, r);
    axi_write(ADDR_COUNT, 8'h00, r);
    axi_write(ADDR_CONTROL, 8'h04, r);
    wait_match(c);
    wait_match(c);
    check("match spacing", c, 12);
    @(posedge aclk);
    check("match width", 32'(match_out), 32'h0000_0000);
    check("irq after match", 32'(irq), 32'h0000_0001);
    axi_write(ADDR_CONTROL, 8'h00, r);
    axi_write(ADDR_MASK, 8'h00, r);
    @(posedge aclk);
    check("irq masked", 32'(irq), 32'h0000_0000);
    axi_write(ADDR_MASK, 8'h01, r);
    @(posedge aclk);
    check("irq unmasked", 32'(irq), 32'h0000_0001);
    axi_read(ADDR_STATUS, d, r);
    check("flag latched", d, 32'h0000_0001);
    @(posedge aclk);
    check("irq after clear", 32'(irq), 32'h0000_0000);
    axi_read(ADDR_STATUS, d, r);
    check("flag cleared", d, 32'h0000_0000);
    $display("done: period and interrupt");
  endtask : test_period

  task automatic test_prescale;
    logic [1:0] r;
    int         c;
    int         ratio [4] = '{1, 4, 16, 16};
    axi_write(ADDR_PERIOD, 8'h01, r);
    for (int i = 0; i < 4; i++) begin
      axi_write(ADDR_CONTROL, 8'h04 | 8'(i), r);
      wait_match(c);
      wait_match(c);
      check("prescaled spacing", c, 8 * ratio[i]);
    end
    $display("done: prescaler");
  endtask : test_prescale

  task automatic test_postscale;
    logic [31:0] d;
    logic [1:0]  r;
    int          pulses;
    int          n;
    int          code [4] = '{0, 1, 7, 15};
    axi_write(ADDR_PERIOD, 8'h00, r);
    foreach (code[i]) begin
      axi_write(ADDR_CONTROL, 8'h00, r);
      axi_write(ADDR_COUNT, 8'h00, r);
      axi_read(ADDR_STATUS, d, r);
      axi_write(ADDR_CONTROL, 8'(code[i] << 3) | 8'h04, r);
      pulses = 0;
      n = 0;
      while (n < 500) begin
        @(posedge aclk);
        n++;
        if (irq === 1'b1) break;
        if (match_out === 1'b1) pulses++;
      end
      if (n >= 500) give_up("postscaled flag");
      check("postscale pulses", pulses, code[i] + 1);
    end
    $display("done: postscaler");
  endtask : test_postscale

  task automatic test_hold;
    logic [31:0] d;
    logic [1:0]  r;
    int          m;
    axi_write(ADDR_CONTROL, 8'h00, r);
    axi_write(ADDR_PERIOD, 8'h40, r);
    axi_write(ADDR_COUNT, 8'h40, r);
    m = match_cnt;
    repeat (40) @(posedge aclk);
    axi_read(ADDR_COUNT, d, r);
    check("count held off", d, 32'h0000_0040);
    check("no match off", match_cnt, m);
    axi_write(ADDR_PERIOD, 8'hFF, r);
    axi_write(ADDR_CONTROL, 8'h04, r);
    axi_read(ADDR_COUNT, d, r);
    check("count kept on", {28'h000_0000, d[7:4]}, 32'h0000_0004);
    $display("done: hold");
  endtask : test_hold

  // Prescaler restart: first match only after a full 1:16 run
  task automatic test_restart;
    logic [1:0] r;
    int         c;
    int         gap [3] = '{5, 23, 41};
    axi_write(ADDR_PERIOD, 8'h00, r);
    axi_write(ADDR_CONTROL, 8'h06, r);
    foreach (gap[i]) begin
      repeat (gap[i]) @(posedge aclk);
      axi_write(ADDR_COUNT, 8'h00, r);
      wait_match(c);
      check("restart delay", 32'(c >= 58 && c <= 68), 32'h0000_0001);
    end
    $display("done: prescaler restart");
  endtask : test_restart

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_rw();
    test_period();
    test_prescale();
    test_postscale();
    test_hold();
    test_restart();
    tally_and_finish();
  end

endmodule : period_match_timer8_bench

`default_nettype wire
